/* pkg/wcr_pkg.sv */
package wcr_pkg;
    // ------------------------------------------------------------------
    // Link commands
    // ------------------------------------------------------------------
    localparam logic [7:0]  GENERIC_REGISTER_READ_CMD  = 8'h65;
    localparam logic [7:0]  GENERIC_REGISTER_WRITE_CMD = 8'h71;
    localparam logic [7:0]  SET_BURST_LENGTH_CMD       = 8'hc0;

    // ------------------------------------------------------------------
    // Register addresses seen by the generic register commands
    // ------------------------------------------------------------------
    localparam logic [23:0] WRAP_CONFIG_BOOT_ADDR      = 24'h000005;
    localparam logic [23:0] WRAP_CONFIG_LIVE_ADDR      = 24'h800005;

    // ------------------------------------------------------------------
    // Field layout and factory value
    // ------------------------------------------------------------------
    localparam int          DRIVE_CODE_MSB             = 7;
    localparam int          DRIVE_CODE_LSB             = 5;
    localparam int          WRAP_DISABLE_BIT           = 4;
    localparam int          WRAP_LENGTH_MSB            = 1;
    localparam int          WRAP_LENGTH_LSB            = 0;
    localparam logic [7:0]  WRAP_CONFIG_FACTORY        = 8'h10;
    localparam logic [7:0]  WRAP_CONFIG_USED_MASK      = 8'hf3;
    localparam logic [7:0]  WRAP_BASE_MASK             = 8'h07;

    // ------------------------------------------------------------------
    // Frame bit positions (single-line link, count of bits taken)
    // ------------------------------------------------------------------
    localparam logic [5:0]  CMD_LAST_BIT               = 6'h07;
    localparam logic [5:0]  SBL_LAST_BIT               = 6'h0f;
    localparam logic [5:0]  ADDR_LAST_BIT              = 6'h1f;
    localparam logic [5:0]  WRITE_LAST_BIT             = 6'h27;
    localparam logic [5:0]  BIT_COUNT_TOP              = 6'h3f;
endpackage

/* hw/wcr_regs.sv */
`timescale 1ns/100ps

module wcr_regs #(
    parameter int          ADDR_W       = 32,
    parameter logic [7:0]  QUAD_IO_CMD  = 8'h01,
    parameter logic [7:0]  DDR_QUAD_CMD = 8'h02
) (
    input  wire logic              i_mclk,
    input  wire logic              i_arst_n,
    input  wire logic              i_soft_reset,
    input  wire logic              i_sck,
    input  wire logic              i_cs_n,
    input  wire logic              i_si,
    output logic                   o_so,
    output logic                   o_so_oe,
    input  wire logic              i_rd_start,
    input  wire logic [7:0]        i_rd_cmd,
    input  wire logic              i_rd_main_array,
    input  wire logic [ADDR_W-1:0] i_rd_addr,
    input  wire logic              i_rd_next,
    output logic [ADDR_W-1:0]      o_rd_addr,
    output logic                   o_rd_wrapping,
    output logic [2:0]             o_drive_code,
    output logic [7:0]             o_wrap_config_boot,
    output logic [7:0]             o_wrap_config_live
);
    import wcr_pkg::*;

    // ------------------------------------------------------------------
    // Link side: runs on the host clock, frame state cleared by chip select
    // ------------------------------------------------------------------
    logic [5:0]  bit_cnt_r;
    logic [31:0] shift_r;
    logic [7:0]  cmd_r;
    logic [7:0]  out_sh_r;
    logic        reading_r;

    // Register copies seen by the link
    logic [7:0]  boot_s1_r;
    logic [7:0]  boot_s2_r;
    logic [7:0]  live_s1_r;
    logic [7:0]  live_s2_r;

    // Write handshake towards the system clock
    logic [23:0] wr_addr_r;
    logic [7:0]  wr_data_r;
    logic        wr_sbl_r;
    logic        wr_tgl_r;

    // Reply pin
    logic        so_r;
    logic        so_oe_r;

    // ------------------------------------------------------------------
    // Frame decode
    // ------------------------------------------------------------------
    wire  [31:0] shift_in   = {shift_r[30:0], i_si};
    wire  [23:0] addr_in    = shift_in[23:0];
    wire  [7:0]  byte_in    = shift_in[7:0];
    wire         is_read    = (cmd_r == GENERIC_REGISTER_READ_CMD);
    wire         is_write   = (cmd_r == GENERIC_REGISTER_WRITE_CMD);
    wire         is_sbl     = (cmd_r == SET_BURST_LENGTH_CMD);
    wire         read_load  = is_read && (bit_cnt_r == ADDR_LAST_BIT);
    wire         write_done = is_write && (bit_cnt_r == WRITE_LAST_BIT);
    wire         sbl_done   = is_sbl && (bit_cnt_r == SBL_LAST_BIT);
    wire  [7:0]  read_byte  = (addr_in == WRAP_CONFIG_BOOT_ADDR) ? boot_s2_r :
                              (addr_in == WRAP_CONFIG_LIVE_ADDR) ? live_s2_r : 8'h00;

    // ------------------------------------------------------------------
    // Frame bit counter: saturates so a long frame cannot alias a command
    // ------------------------------------------------------------------
    // Chip select clears it, so a cut frame leaves nothing behind
    wire         cnt_at_top  = (bit_cnt_r == BIT_COUNT_TOP);
    wire         cmd_taken   = (bit_cnt_r == CMD_LAST_BIT);
    wire  [5:0]  bit_cnt_nxt = cnt_at_top ? bit_cnt_r : bit_cnt_r + 6'h01;
    wire  [7:0]  rot_byte    = {out_sh_r[6:0], out_sh_r[7]};

    always_ff @(posedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            bit_cnt_r <= 6'h00;
        end else begin
            bit_cnt_r <= bit_cnt_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Input shifter and opcode capture
    // ------------------------------------------------------------------
    always_ff @(posedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            shift_r <= 32'h0000_0000;
        end else begin
            shift_r <= shift_in;
        end
    end

    always_ff @(posedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            cmd_r <= 8'h00;
        end else if (cmd_taken) begin
            cmd_r <= byte_in;
        end
    end

    // ------------------------------------------------------------------
    // Reply shifter: the byte repeats while the host keeps clocking
    // ------------------------------------------------------------------
    always_ff @(posedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            out_sh_r  <= 8'h00;
            reading_r <= 1'b0;
        end else if (read_load) begin
            out_sh_r  <= read_byte;
            reading_r <= 1'b1;
        end else begin
            out_sh_r  <= rot_byte;
        end
    end

    // ------------------------------------------------------------------
    // Register values for link reads
    // ------------------------------------------------------------------
    // They cross as levels and only move on link clocks, inside frames; a read within two
    // link clocks of a change may still show the old byte
    always_ff @(posedge i_sck or negedge i_arst_n) begin
        if (!i_arst_n) begin
            boot_s1_r <= 8'h00;
            boot_s2_r <= 8'h00;
        end else begin
            boot_s1_r <= o_wrap_config_boot;
            boot_s2_r <= boot_s1_r;
        end
    end

    always_ff @(posedge i_sck or negedge i_arst_n) begin
        if (!i_arst_n) begin
            live_s1_r <= 8'h00;
            live_s2_r <= 8'h00;
        end else begin
            live_s1_r <= o_wrap_config_live;
            live_s2_r <= live_s1_r;
        end
    end

    // ------------------------------------------------------------------
    // Write capture: the word stays put until the next write or burst-length frame is taken
    // ------------------------------------------------------------------
    always_ff @(posedge i_sck or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_addr_r <= 24'h000000;
            wr_data_r <= 8'h00;
            wr_sbl_r  <= 1'b0;
            wr_tgl_r  <= 1'b0;
        end else if (!i_cs_n && (write_done || sbl_done)) begin
            wr_addr_r <= shift_in[31:8];
            wr_data_r <= byte_in;
            wr_sbl_r  <= sbl_done;
            wr_tgl_r  <= ~wr_tgl_r;
        end
    end

    // ------------------------------------------------------------------
    // Reply pin
    // ------------------------------------------------------------------
    // Launched on the falling edge so the host samples it half a period later
    always_ff @(negedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            so_r    <= 1'b0;
            so_oe_r <= 1'b0;
        end else begin
            so_r    <= out_sh_r[7];
            so_oe_r <= reading_r;
        end
    end

    assign o_so    = so_r;
    assign o_so_oe = so_oe_r;

    // ------------------------------------------------------------------
    // System side: registers and read address generator
    // ------------------------------------------------------------------
    logic [2:0]        tgl_sync_r;
    logic [7:0]        boot_r;
    logic [7:0]        live_r;
    logic [ADDR_W-1:0] rd_addr_r;
    logic              wrapping_r;
    logic [2:0]        drive_r;

    wire        wr_event  = tgl_sync_r[2] ^ tgl_sync_r[1];
    wire [7:0]  wr_clean  = wr_data_r & WRAP_CONFIG_USED_MASK;
    wire        wr_boot   = wr_event && !wr_sbl_r && (wr_addr_r == WRAP_CONFIG_BOOT_ADDR);
    wire        wr_live   = wr_event && (wr_sbl_r || (wr_addr_r == WRAP_CONFIG_LIVE_ADDR));

    // Wrap controls come from the live copy only
    wire [1:0]  wrap_len  = live_r[WRAP_LENGTH_MSB:WRAP_LENGTH_LSB];
    wire        wrap_on   = !live_r[WRAP_DISABLE_BIT];
    wire [7:0]  len_mask  = 8'(({1'b0, WRAP_BASE_MASK} << wrap_len) | WRAP_BASE_MASK);
    wire [ADDR_W-1:0] mask_w = ADDR_W'(len_mask);
    wire        wrap_cmd  = (i_rd_cmd == QUAD_IO_CMD) || (i_rd_cmd == DDR_QUAD_CMD);
    wire        start_wrap = wrap_on && wrap_cmd && i_rd_main_array;
    wire [ADDR_W-1:0] addr_inc = rd_addr_r + ADDR_W'(1);
    wire [ADDR_W-1:0] addr_wrapped = (rd_addr_r & ~mask_w) | (addr_inc & mask_w);

    // ------------------------------------------------------------------
    // Write toggle synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tgl_sync_r <= 3'b000;
        end else begin
            tgl_sync_r <= {tgl_sync_r[1:0], wr_tgl_r};
        end
    end

    // ------------------------------------------------------------------
    // Boot copy
    // ------------------------------------------------------------------
    // Power-on value of the boot copy stands in for the non-volatile cells;
    // as flops, a hardware reset also returns it to the factory value
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            boot_r <= WRAP_CONFIG_FACTORY;
        end else if (wr_boot) begin
            boot_r <= wr_clean;
        end
    end

    // ------------------------------------------------------------------
    // Live copy: software reset beats a write landing in the same cycle
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            live_r <= WRAP_CONFIG_FACTORY;
        end else if (i_soft_reset) begin
            live_r <= boot_r;
        end else if (wr_live) begin
            live_r <= wr_clean;
        end
    end

    // ------------------------------------------------------------------
    // Array read address: a new start beats a step in the same cycle
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rd_addr_r <= '0;
        end else if (i_rd_start) begin
            rd_addr_r <= i_rd_addr;
        end else if (i_rd_next) begin
            rd_addr_r <= wrapping_r ? addr_wrapped : addr_inc;
        end
    end

    // Wrap mode is fixed per read; the length still follows the live copy
    // at every step, so a length change mid-burst takes effect at once
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wrapping_r <= 1'b0;
        end else if (i_rd_start) begin
            wrapping_r <= start_wrap;
        end
    end

    // ------------------------------------------------------------------
    // Drive code
    // ------------------------------------------------------------------
    // Code 000 is passed on as is; the pad logic treats it like 011,
    // so no remapping is done here
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            drive_r <= WRAP_CONFIG_FACTORY[DRIVE_CODE_MSB:DRIVE_CODE_LSB];
        end else begin
            drive_r <= live_r[DRIVE_CODE_MSB:DRIVE_CODE_LSB];
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_rd_addr          = rd_addr_r;
    assign o_rd_wrapping      = wrapping_r;
    assign o_drive_code       = drive_r;
    assign o_wrap_config_boot = boot_r;
    assign o_wrap_config_live = live_r;
endmodule

/* verification/wcr_host.sv */
`timescale 1ns/100ps
// ----
// Link host: clock runs only inside frames
// ----
module wcr_host (
    output logic      sck,
    output logic      cs_n,
    output logic      si,
    input  wire logic so
);
    initial begin
        sck = 0;
        cs_n = 1;
        si = 0;
    end
    // Bits sent MSB first, r extra clocks sample the reply; si toggles once released
    task automatic xfer(input logic [39:0] b, input int n, input int r,
                        output logic [7:0] d);
        #7;
        for (int i = n - 1; i >= -r; i--) begin
            si = (i >= 0) ? b[i] : ~si;
            cs_n = 0;
            #24 sck = 1;
            d = {d[6:0], so};
            #24 sck = 0;
        end
        #24 cs_n = 1;
        si = ~si;
        #200;
    endtask
endmodule

/* verification/wcr_regs_props.sv */
`timescale 1ns/100ps
module wcr_regs_props #(
    parameter int         ADDR_W       = 32,
    parameter logic [7:0] QUAD_IO_CMD  = 8'h01,
    parameter logic [7:0] DDR_QUAD_CMD = 8'h02
) (
    input wire logic              i_mclk,
    input wire logic              i_arst_n,
    input wire logic              i_soft_reset,
    input wire logic              i_rd_start,
    input wire logic [7:0]        i_rd_cmd,
    input wire logic              i_rd_main_array,
    input wire logic [ADDR_W-1:0] i_rd_addr,
    input wire logic              i_rd_next,
    input wire logic [ADDR_W-1:0] o_rd_addr,
    input wire logic              o_rd_wrapping,
    input wire logic              o_so_oe,
    input wire logic [2:0]        o_drive_code,
    input wire logic [7:0]        o_wrap_config_boot,
    input wire logic [7:0]        o_wrap_config_live
);
    // ----
    // Properties
    // ----
    logic [ADDR_W-1:0] msk;
    assign msk = (ADDR_W'(8) << o_wrap_config_live[1:0]) - ADDR_W'(1);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);
    chk_reset_load: assert property ($rose(i_arst_n) |-> o_wrap_config_live == 8'h10
        && o_wrap_config_boot == 8'h10) else $error("reset values wrong");
    chk_soft_copy: assert property (i_soft_reset |=>
        o_wrap_config_live == $past(o_wrap_config_boot)) else $error("soft reset copy");
    chk_drive_follow: assert property (o_drive_code ==
        $past(o_wrap_config_live[7:5])) else $error("drive code lags");
    chk_start_addr: assert property (i_rd_start |=>
        o_rd_addr == $past(i_rd_addr)) else $error("start address");
    chk_wrap_sel: assert property (i_rd_start |=> o_rd_wrapping == $past(i_rd_main_array
        && !o_wrap_config_live[4] && (i_rd_cmd == QUAD_IO_CMD || i_rd_cmd == DDR_QUAD_CMD)))
        else $error("wrap select");
    chk_wrap_hold: assert property (!i_rd_start |=> $stable(o_rd_wrapping))
        else $error("wrap mode moved");
    chk_seq_step: assert property (i_rd_next && !i_rd_start && !o_rd_wrapping |=>
        o_rd_addr == $past(o_rd_addr) + 1) else $error("sequential step");
    chk_wrap_step: assert property (i_rd_next && !i_rd_start && o_rd_wrapping |=>
        o_rd_addr == (($past(o_rd_addr) & ~$past(msk)) | (($past(o_rd_addr) + 1) & $past(msk))))
        else $error("wrapped step");
    cover property (i_soft_reset);
    cover property (o_rd_wrapping && i_rd_next);
    cover property (o_so_oe);
endmodule
bind wcr_regs wcr_regs_props #(.ADDR_W(ADDR_W), .QUAD_IO_CMD(QUAD_IO_CMD),
    .DDR_QUAD_CMD(DDR_QUAD_CMD)) chk (.*);

/* verification/wcr_regs_bench.sv */
`timescale 1ns/100ps
module wcr_regs_bench;
    import wcr_pkg::*;
    logic        ck = 0, rst_n = 0, sr = 0, rs = 0, rn = 0, rm = 0, w;
    logic [7:0]  rc = 0, d, v, seed = 8'h61;
    logic [31:0] ra = 0;
    wire         sck, cs_n, si, so, ow, oe;
    logic        oe_seen = 0;
    wire [31:0]  oa;
    wire [2:0]   dc;
    wire [7:0]   ob, ol;
    int          n_fail = 0, checks = 0, live, a, msk;
    always #10 ck = ~ck;
    wcr_host host (.sck(sck), .cs_n(cs_n), .si(si), .so(so));
    wcr_regs uut (.i_mclk(ck), .i_arst_n(rst_n), .i_soft_reset(sr), .i_sck(sck),
        .i_cs_n(cs_n), .i_si(si), .o_so(so), .o_so_oe(oe), .i_rd_start(rs), .i_rd_cmd(rc),
        .i_rd_main_array(rm), .i_rd_addr(ra), .i_rd_next(rn), .o_rd_addr(oa),
        .o_rd_wrapping(ow), .o_drive_code(dc), .o_wrap_config_boot(ob),
        .o_wrap_config_live(ol));
    always @(posedge sck) if (oe) oe_seen = 1;
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task chk(input string s, input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", s, e, g);
        end
    endtask
    task end_sim;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task tick;
        @(posedge ck);
        #1;
    endtask
    task wr(input logic [23:0] ad, input logic [7:0] x);
        host.xfer({GENERIC_REGISTER_WRITE_CMD, ad, x}, 40, 0, d);
        tick;
    endtask
    task set_burst_length_cmd(input logic [7:0] x);
        host.xfer({24'h0, SET_BURST_LENGTH_CMD, x}, 16, 0, d);
        tick;
    endtask
    task rd(input logic [23:0] ad, input logic [7:0] e);
        oe_seen = 0;
        host.xfer({8'h0, GENERIC_REGISTER_READ_CMD, ad}, 32, 8, d);
        chk("link read", d, e);
        chk("reply enable", oe_seen, 1'b1);
        chk("reply idle", {oe, so}, 2'b00);
    endtask
    initial begin
        repeat (2) @(posedge ck);
        #1 rst_n = 1;
        tick;
        chk("boot", ob, 8'h10);
        chk("live", ol, 8'h10);
        chk("drive", dc, 3'h0);
        rd(WRAP_CONFIG_BOOT_ADDR, 8'h10);
        rd(24'h000123, 8'h00);
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            wr(WRAP_CONFIG_LIVE_ADDR, seed);
            live = seed & 8'hf3;
            tick;
            chk("live", ol, live);
            chk("drive", dc, live[7:5]);
            rd(WRAP_CONFIG_LIVE_ADDR, 8'(live));
        end
        wr(WRAP_CONFIG_BOOT_ADDR, 8'h63);
        set_burst_length_cmd(8'h02);
        chk("boot", ob, 8'h63);
        rd(WRAP_CONFIG_BOOT_ADDR, 8'h63);
        chk("live", ol, 8'h02);
        sr = 1;
        tick;
        sr = 0;
        tick;
        chk("live", ol, 8'h63);
        for (int c = 0; c < 8; c++) begin
            v = 8'({c[2], 2'b00, c[1:0]});
            set_burst_length_cmd(v);
            msk = (8 << c[1:0]) - 1;
            for (int m = 0; m < 6; m++) begin
                seed = lfsr(seed);
                rc = 8'(m % 3 + 1);
                rm = m > 2;
                ra = {24'h0, seed};
                rn = 0;
                rs = 1;
                tick;
                rs = 0;
                a = seed;
                w = !v[4] && rm && rc != 8'h03;
                chk("wrap", ow, w);
                for (int s = 0; s < 70; s++) begin
                    rn = 1;
                    tick;
                    a = w ? ((a & ~msk) | ((a + 1) & msk)) : a + 1;
                    chk("addr", oa, a);
                end
            end
        end
        rn = 0;
        rst_n = 0;
        tick;
        rst_n = 1;
        tick;
        chk("live", ol, 8'h10);
        end_sim;
    end
    initial begin
        #400000;
        n_fail++;
        end_sim;
    end
endmodule
